//--- serial_queue_config_chain.sv
// Serial setup chain loader with daisy-chain pass-through
//
// Function
// - Setup bit is captured on serial clock rise only while chain enable in is low.
// - Serial clock shifts setup data only when serial programming is strapped as reset is released.
// - Chain enable out signals finished configuration, serial or default.
// - After completion chain enable out follows chain enable in, low and high.
// - Device is ready for queue operations once chain enable out has gone low.
// - Once the serial chain is loaded, with chain enable in low, serial input passes to serial output.
// - Queue setup is loaded bit by bit through a shift register in serial mode; default mode loads the default word.
`timescale 1ns/1ps
`include "queue_cfg_regs.svh"

module serial_queue_config_chain (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_serial_mode,
    input wire logic i_sclk,
    input wire logic i_chain_enable_in_b,
    input wire logic i_serial_in,
    output logic o_serial_out,
    output logic o_chain_enable_out_b,
    output logic o_config_ready,
    output logic [`CFG_CHAIN_LEN-1:0] o_cfg_word
);

    // ---------------- Link clock domain ----------------

    queue_cfg_pkg::link_in_t link_in;
    queue_cfg_pkg::cfg_word_t chain_q;
    queue_cfg_pkg::cfg_word_t chain_d;
    queue_cfg_pkg::cfg_cnt_t count_q;
    queue_cfg_pkg::cfg_cnt_t count_d;
    logic loaded_q;
    logic loaded_d;
    logic serial_out_q;
    logic serial_out_d;
    logic serial_en_link;
    logic mode_serial_q;
    wire shift_en;
    wire last_bit;
    wire pass_en;

    // Serial pins are source-synchronous to the link clock and sampled on its rise
    assign link_in.enable_b = i_chain_enable_in_b;
    assign link_in.data = i_serial_in;

    // Strapped mode crosses from the core domain as a steady level
    bit_sync u_mode_sync (
        .i_clk(i_sclk),
        .i_rst_b(i_rst_b),
        .i_level(mode_serial_q),
        .o_level(serial_en_link)
    );

    // Shift only in serial mode, while enabled, and until the chain is full
    assign shift_en = serial_en_link && !link_in.enable_b && !loaded_q;
    assign last_bit = (count_q == (`CFG_CHAIN_LEN_CNT - 6'h01));
    assign pass_en = loaded_q && !link_in.enable_b;

    // New bits enter at the top so the first bit lands in bit 0
    assign chain_d = shift_en ? {link_in.data, chain_q[`CFG_CHAIN_LEN-1:1]} : chain_q;
    assign count_d = shift_en ? count_q + 6'h01 : count_q;
    assign loaded_d = loaded_q | (shift_en && last_bit);
    // Low before completion so a downstream device sees no stray data
    assign serial_out_d = pass_en ? link_in.data : 1'b0;

    // Setup chain and bit counter
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            chain_q <= `CFG_CHAIN_RESET;
            count_q <= `CFG_CNT_RESET;
        end else begin
            chain_q <= chain_d;
            count_q <= count_d;
        end
    end

    // Completion flag and pass-through output
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            loaded_q <= 1'b0;
            serial_out_q <= 1'b0;
        end else begin
            loaded_q <= loaded_d;
            serial_out_q <= serial_out_d;
        end
    end

    assign o_serial_out = serial_out_q;

    // ---------------- Core clock domain ----------------

    queue_cfg_pkg::cfg_state_t state_q;
    queue_cfg_pkg::cfg_state_t state_d;
    queue_cfg_pkg::link_status_t status;
    queue_cfg_pkg::cfg_word_t cfg_word_q;
    queue_cfg_pkg::cfg_word_t cfg_word_d;
    logic mode_serial_d;
    logic loaded_core;
    logic enable_in_core;
    logic chain_out_b_q;
    logic chain_out_b_d;
    logic ready_q;
    logic ready_d;
    logic strap_serial;
    logic [1:0] strap_wait_q;
    logic [1:0] strap_wait_d;
    wire in_done;
    wire load_word;
    wire strap_ready;
    wire take_strap;
    wire take_default;

    // Link completion is a level that only ever rises, so two flops suffice
    bit_sync u_loaded_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_level(loaded_q),
        .o_level(loaded_core)
    );

    // Chain enable in is synchronised so the output works with the serial clock stopped
    bit_sync u_enable_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_level(i_chain_enable_in_b),
        .o_level(enable_in_core)
    );

    assign status.serial_en = mode_serial_q;
    assign status.loaded = loaded_core;

    // The strap pin is asynchronous to the core clock, so it is synchronised first
    bit_sync u_strap_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_level(i_serial_mode),
        .o_level(strap_serial)
    );

    // The strap is judged only once the synchronisers have filled after reset;
    // this also keeps the reset value of the enable synchroniser off the output
    assign strap_ready = (strap_wait_q == `CFG_STRAP_WAIT);
    assign strap_wait_d = strap_ready ? strap_wait_q : strap_wait_q + 2'h1;
    assign take_strap = (state_q == queue_cfg_pkg::ST_STRAP) && strap_ready;
    assign take_default = take_strap && !strap_serial;

    // Strap is caught once after reset release, never under reset
    assign mode_serial_d = take_strap ? strap_serial : mode_serial_q;

    // The chain is frozen once loaded, so sampling it here is a safe word crossing
    assign load_word = (state_q == queue_cfg_pkg::ST_SERIAL) && status.serial_en &&
        status.loaded;

    // Next state of the configuration sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            queue_cfg_pkg::ST_STRAP: begin
                if (strap_ready) begin
                    state_d = strap_serial ? queue_cfg_pkg::ST_SERIAL : queue_cfg_pkg::ST_DONE;
                end
            end
            queue_cfg_pkg::ST_SERIAL: begin
                if (status.loaded) begin
                    state_d = queue_cfg_pkg::ST_DONE;
                end
            end
            queue_cfg_pkg::ST_DONE: begin
                state_d = queue_cfg_pkg::ST_DONE;
            end
            default: begin
                state_d = queue_cfg_pkg::ST_STRAP;
            end
        endcase
    end

    assign in_done = (state_q == queue_cfg_pkg::ST_DONE);

    // Default word is taken when leaving the strap state in default mode
    assign cfg_word_d = load_word ? chain_q :
        take_default ? `CFG_DEFAULT_WORD :
        cfg_word_q;

    // Chain enable out held high until done, then follows the input
    assign chain_out_b_d = in_done ? enable_in_core : 1'b1;
    // Ready is sticky from the first low of chain enable out
    assign ready_d = ready_q | !chain_out_b_q;

    // Sequencer and strap capture
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= queue_cfg_pkg::ST_STRAP;
            mode_serial_q <= 1'b0;
            strap_wait_q <= `CFG_STRAP_RESET;
        end else begin
            state_q <= state_d;
            mode_serial_q <= mode_serial_d;
            strap_wait_q <= strap_wait_d;
        end
    end

    // Registered outputs of the core domain
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_word_q <= `CFG_CHAIN_RESET;
            chain_out_b_q <= 1'b1;
            ready_q <= 1'b0;
        end else begin
            cfg_word_q <= cfg_word_d;
            chain_out_b_q <= chain_out_b_d;
            ready_q <= ready_d;
        end
    end

    assign o_chain_enable_out_b = chain_out_b_q;
    assign o_config_ready = ready_q;
    assign o_cfg_word = cfg_word_q;

    // ---------------- Checks on the link clock ----------------

    // A bit is counted only on an edge where chain enable in was low
    shift_gate_a: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
        (count_q != $past(count_q)) |-> $past(!i_chain_enable_in_b))
        else $error("bit shifted while chain enable in was high");

    // Without the serial strap the chain never moves
    mode_gate_a: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
        !serial_en_link |=> (chain_q == $past(chain_q)) && (count_q == $past(count_q)))
        else $error("setup chain moved outside serial mode");

    // The sampled input bit lands at the top of the chain
    shift_load_a: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
        shift_en |=> (chain_q[`CFG_CHAIN_LEN-1] == $past(i_serial_in))
            && (chain_q[`CFG_CHAIN_LEN-2:0] == $past(chain_q[`CFG_CHAIN_LEN-1:1])))
        else $error("setup chain did not shift in the serial bit");

    // Completion only with the full chain length counted
    chain_count_a: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
        $rose(loaded_q) |-> (count_q == `CFG_CHAIN_LEN_CNT) && serial_en_link)
        else $error("completion declared before the full chain was shifted");

    // After loading, serial output repeats serial input one edge later
    so_pass_a: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
        (loaded_q && !i_chain_enable_in_b) |=> (o_serial_out == $past(i_serial_in)))
        else $error("serial data not passed through after loading");

    // Before loading the serial output stays low for the next device
    so_idle_a: assert property (@(posedge i_sclk) disable iff (!i_rst_b)
        !loaded_q |=> !o_serial_out)
        else $error("serial output active before the chain was loaded");

    // ---------------- Checks on the core clock ----------------

    // Chain enable out may fall only once configuration is finished
    enable_out_done_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_chain_enable_out_b) |-> $past(state_q == queue_cfg_pkg::ST_DONE))
        else $error("chain enable out fell before configuration finished");

    // Once done, chain enable out repeats the synchronised input one edge later
    enable_out_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        in_done |=> (o_chain_enable_out_b == $past(enable_in_core)))
        else $error("chain enable out did not follow chain enable in");

    // Ready is raised the edge after chain enable out goes low and holds for one more edge
    ready_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(o_chain_enable_out_b) |=> o_config_ready [*2])
        else $error("device not ready after chain enable out went low");

    // Serial load reaches the core on the core edge after the loaded flag is seen
    load_reach_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_q == queue_cfg_pkg::ST_SERIAL && status.loaded) |=>
        (o_cfg_word == $past(chain_q)) && in_done)
        else $error("loaded setup word not taken by the core");

    // Default programming loads the default word as the strap is taken
    default_word_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        take_default |=> (o_cfg_word == `CFG_DEFAULT_WORD) && in_done)
        else $error("default word not loaded in default programming");

    // The strap is taken once; the mode stays fixed until the next reset
    strap_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (state_q != queue_cfg_pkg::ST_STRAP) |=> $stable(mode_serial_q))
        else $error("programming mode changed after the strap was taken");

    // Main scenarios
    serial_done_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        mode_serial_q && $fell(o_chain_enable_out_b));
    default_done_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        !mode_serial_q && $fell(o_chain_enable_out_b));
    enable_out_rise_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        o_config_ready && $rose(o_chain_enable_out_b));
    pass_data_c: cover property (@(posedge i_sclk) disable iff (!i_rst_b)
        pass_en && i_serial_in);
    strap_serial_c: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        take_strap && strap_serial);

endmodule

//--- queue_cfg_regs.svh
// Constants for the serial queue setup chain
`ifndef QUEUE_CFG_REGS_SVH
`define QUEUE_CFG_REGS_SVH

// Length of the setup shift register chain in bits
`define CFG_CHAIN_LEN 32
// Width of the shifted-bit counter, wide enough to hold the chain length
`define CFG_CNT_W 6
// Chain length at counter width, used for the completion compare
`define CFG_CHAIN_LEN_CNT 6'h20
// Counter reset value
`define CFG_CNT_RESET 6'h00
// Setup word used when default programming is strapped
`define CFG_DEFAULT_WORD 32'h0000_0000
// Setup chain reset value
`define CFG_CHAIN_RESET 32'h0000_0000
// Core clock edges the strap synchroniser needs to fill after reset
`define CFG_STRAP_WAIT 2'h2
// Strap wait counter reset value
`define CFG_STRAP_RESET 2'h0

`endif

//--- queue_cfg_pkg.sv
// Types shared by the serial queue setup chain
`include "queue_cfg_regs.svh"

package queue_cfg_pkg;

    // Configuration sequencing in the core clock domain
    typedef enum logic [1:0] {
        ST_STRAP,
        ST_SERIAL,
        ST_DONE
    } cfg_state_t;

    // Serial pins as sampled on the link clock
    typedef struct packed {
        logic enable_b;
        logic data;
    } link_in_t;

    // Link-side status handed to the core domain
    typedef struct packed {
        logic serial_en;
        logic loaded;
    } link_status_t;

    typedef logic [`CFG_CHAIN_LEN-1:0] cfg_word_t;
    typedef logic [`CFG_CNT_W-1:0] cfg_cnt_t;

endpackage

//--- bit_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps

module bit_sync (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_level,
    output logic o_level
);

    logic meta_q;
    logic sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_level;
            sync_q <= meta_q;
        end
    end

    assign o_level = sync_q;

endmodule

//--- host_chain_model.sv
// Host model that drives the serial setup chain of a lone device
`timescale 1ns/1ps

module host_chain_model (
    output logic o_sclk,
    output logic o_chain_enable_in_b,
    output logic o_serial_data
);
    // The last stage's serial output has no input here and stays open
    // Clock stands low outside frames; enable idles high
    initial begin
        o_sclk = 1'b0;
        o_chain_enable_in_b = 1'b1;
        o_serial_data = 1'b0;
    end

    // One serial clock pulse at 30 ns; data and enable change after the fall
    task automatic pulse(input logic en_b, input logic b);
        o_chain_enable_in_b = en_b;
        o_serial_data = b;
        #15 o_sclk = 1'b1;
        #15 o_sclk = 1'b0;
    endtask

    // Released data line toggles so a stale bit cannot pass for a match
    task automatic release_line();
        o_serial_data = ~o_serial_data;
    endtask

    // Enable level change with the serial clock stopped
    // A lone device has no previous stage, so the host stands in for it
    task automatic set_enable(input logic en_b);
        o_chain_enable_in_b = en_b;
    endtask
endmodule

//--- serial_queue_config_chain_test.sv
// Self-checking bench for the serial queue setup chain
`timescale 1ns/1ps
`include "queue_cfg_regs.svh"

module serial_queue_config_chain_test;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_serial_mode = 1'b0;
    logic sclk, en_in_b, sdata, o_serial_out, o_chain_enable_out_b, o_config_ready;
    logic [`CFG_CHAIN_LEN-1:0] o_cfg_word;
    int error_cnt = 0;
    int comparisons = 0;

    always #12.5 i_clk = ~i_clk;

    serial_queue_config_chain uut (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_serial_mode(i_serial_mode), .i_sclk(sclk), .i_chain_enable_in_b(en_in_b),
        .i_serial_in(sdata), .o_serial_out(o_serial_out),
        .o_chain_enable_out_b(o_chain_enable_out_b), .o_config_ready(o_config_ready),
        .o_cfg_word(o_cfg_word));

    host_chain_model host (.o_sclk(sclk), .o_chain_enable_in_b(en_in_b),
        .o_serial_data(sdata));

    // Compare and count; report a mismatch at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Reset for 22 cycles with the strap set; serial clock pulses during reset
    task automatic do_reset(input logic mode);
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        i_serial_mode <= mode;
        host.pulse(1'b1, 1'b0);
        host.pulse(1'b1, 1'b1);
        repeat (19) @(posedge i_clk);
        #1;
        check({31'h0, o_chain_enable_out_b}, 32'h1);
        check({31'h0, o_config_ready}, 32'h0);
        check(o_cfg_word, 32'h0);
        check({31'h0, o_serial_out}, 32'h0);
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clk);
    endtask

    // Bounded wait for the sticky ready flag
    task automatic wait_ready();
        // No queue selection is requested before ready
        for (int i = 0; i < 20 && o_config_ready !== 1'b1; i++) @(posedge i_clk);
        #1;
    endtask

    // Enable out must follow enable in, both ways, after completion
    task automatic check_follow();
        host.set_enable(1'b1);
        repeat (6) @(posedge i_clk);
        #1;
        check({31'h0, o_chain_enable_out_b}, 32'h1);
        host.set_enable(1'b0);
        repeat (6) @(posedge i_clk);
        #1;
        check({31'h0, o_chain_enable_out_b}, 32'h0);
    endtask

    // Default programming: done without the serial clock, shifting ignored
    task automatic test_default();
        do_reset(1'b0);
        host.set_enable(1'b0);
        wait_ready();
        check({31'h0, o_config_ready}, 32'h1);
        check({31'h0, o_chain_enable_out_b}, 32'h0);
        check(o_cfg_word, `CFG_DEFAULT_WORD);
        for (int i = 0; i < 34; i++) host.pulse(1'b0, 1'b1);
        host.release_line();
        repeat (6) @(posedge i_clk);
        check(o_cfg_word, `CFG_DEFAULT_WORD);
        check_follow();
    endtask

    // Serial load with gaps, completion only at full length, then pass-through
    task automatic test_serial();
        logic [31:0] w;
        logic [7:0] p;
        w = 32'hA5C3_1E96;
        p = 8'hB4;
        host.set_enable(1'b1);
        do_reset(1'b1);
        for (int i = 0; i < 3; i++) host.pulse(1'b1, 1'b1);
        for (int i = 0; i < 31; i++) begin
            if (i == 16) begin
                host.pulse(1'b1, ~w[i]);
                host.pulse(1'b1, ~w[i]);
            end
            host.pulse(1'b0, w[i]);
        end
        host.set_enable(1'b0);
        host.release_line();
        repeat (8) @(posedge i_clk);
        check({31'h0, o_chain_enable_out_b}, 32'h1);
        check({31'h0, o_serial_out}, 32'h0);
        check({31'h0, o_config_ready}, 32'h0);
        host.pulse(1'b0, w[31]);
        host.release_line();
        wait_ready();
        check(o_cfg_word, w);
        check({31'h0, o_chain_enable_out_b}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            host.pulse(1'b0, p[i]);
            check({31'h0, o_serial_out}, {31'h0, p[i]});
        end
        host.release_line();
        check(o_cfg_word, w);
        check_follow();
    endtask

    // Cuts a hang short well beyond the expected run length
    initial begin
        #300000;
        error_cnt++;
        test_done();
    end

    initial begin
        test_default();
        test_serial();
        test_done();
    end
endmodule
